// ===== logic/jtb_pkg.sv
// constants and types shared by the reduced test access port
`default_nettype none
package jtb_pkg;
   // ==========================================
   // instruction register
   localparam int          IR_W         = 4;
   localparam logic [3:0]  IR_BYPASS    = 4'hF;
   localparam logic [3:0]  IR_IDCODE    = 4'h1;
   localparam logic [3:0]  IR_CAPTURE   = 4'h1;   // fixed 01 in the low bits
   localparam logic [3:0]  IR_RESET     = 4'h1;   // idcode selected after reset
   // ==========================================
   // data registers
   localparam int          ID_W         = 32;
   localparam logic [31:0] ID_DEFAULT   = 32'h0000_0001;  // arbitrary neutral value
   // ==========================================
   // pad indices of the four test pins
   localparam int          PIN_N        = 4;
   localparam int          PIN_TCK      = 0;
   localparam int          PIN_TMS      = 1;
   localparam int          PIN_TDI      = 2;
   localparam int          PIN_TDO      = 3;
   localparam logic [3:0]  PIN_OE_N_RST = 4'hF;   // all pins released
   localparam logic [3:0]  PIN_OUT_RST  = 4'h0;
   // ==========================================
   // controller states, one-hot
   typedef enum logic [15:0] {
      ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
      ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020, ST_PSDR = 16'h0040, ST_EX2DR = 16'h0080,
      ST_UPDR = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
      ST_EX1IR = 16'h1000, ST_PSIR = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR  = 16'h8000
   } jtb_state_e;
endpackage : jtb_pkg
`default_nettype wire

// ===== logic/jtb_sync.sv
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
`default_nettype none
module jtb_sync #(
   parameter int W = 4
) (
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } jtb_sync_s;

   jtb_sync_s s_reg;
   jtb_sync_s s_next;

   // ==========================================
   // first stage feeds only the second
   always_comb begin
      s_next        = s_reg;
      s_next.meta   = d_in;
      s_next.stable = s_reg.meta;
      if (!rstn_in) begin
         s_next = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      s_reg <= s_next;
   end

   assign q_out = s_reg.stable;
endmodule : jtb_sync
`default_nettype wire

// ===== logic/jtb_tap.sv
// reduced test access port with bypass and identification only
// What this block does
// - four pins, power-up reset resets controller
// - code 1111 puts one-bit bypass in chain
// - tdi held high during scan selects bypass
// - code 0001 shifts identification value out
// - tdi sampled on rising test clock
// - tdo changes on falling test clock
// - tdo released unless shifting
// - configuration can turn pins into general io
// - in test mode pin cells are closed to user logic
`timescale 1ns/1ps
`default_nettype none
module jtb_tap #(
   parameter logic [31:0] ID_VALUE = jtb_pkg::ID_DEFAULT   // arbitrary value
) (
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RSTN_IN,
   input  wire logic       CFG_TEST_EN_IN,
   input  wire logic [3:0] PAD_IN,
   output var  logic [3:0] PAD_OUT,
   output var  logic [3:0] PAD_OE_N_OUT,
   input  wire logic [3:0] USER_OUT_IN,
   input  wire logic [3:0] USER_OE_N_IN,
   output var  logic [3:0] USER_IN_OUT
);
   typedef struct packed {
      jtb_pkg::jtb_state_e state;
      logic [3:0]          ir;
      logic [3:0]          ir_sh;
      logic [31:0]         dr_sh;
      logic                byp;
      logic                tck_prev;
      logic                test_en;
      logic                cfg_done;
      logic [3:0]          pad_out;
      logic [3:0]          pad_oe_n;
      logic [3:0]          user_in;
   } jtb_tap_s;

   jtb_tap_s   r_reg;
   jtb_tap_s   r_next;
   logic [3:0] pad_s;
   logic       tck_rise;
   logic       tck_fall;
   logic       tms;
   logic       tdi;
   logic       sel_id;
   logic       shifting;

   // ==========================================
   // pad synchroniser
   jtb_sync #(.W(jtb_pkg::PIN_N)) u_sync (
      .clk_in  (CORE_CLK_IN),
      .rstn_in (RSTN_IN),
      .d_in    (PAD_IN),
      .q_out   (pad_s)
   );

   // edge finding on the sampled test clock
   assign tck_rise = pad_s[jtb_pkg::PIN_TCK] & ~r_reg.tck_prev;
   assign tck_fall = ~pad_s[jtb_pkg::PIN_TCK] & r_reg.tck_prev;
   assign tms      = pad_s[jtb_pkg::PIN_TMS];
   assign tdi      = pad_s[jtb_pkg::PIN_TDI];
   assign sel_id   = (r_reg.ir == jtb_pkg::IR_IDCODE);
   assign shifting = (r_reg.state == jtb_pkg::ST_SHIR) || (r_reg.state == jtb_pkg::ST_SHDR);

   // ==========================================
   // next state of the whole port
   always_comb begin
      r_next          = r_reg;
      r_next.tck_prev = pad_s[jtb_pkg::PIN_TCK];
      // configuration taken once after reset release
      if (!r_reg.cfg_done) begin
         r_next.test_en  = CFG_TEST_EN_IN;
         r_next.cfg_done = 1'h1;
      end
      if (r_reg.test_en && tck_rise) begin
         // state advance by tms
         case (r_reg.state)
            jtb_pkg::ST_TLR:   r_next.state = tms ? jtb_pkg::ST_TLR   : jtb_pkg::ST_RTI;
            jtb_pkg::ST_RTI:   r_next.state = tms ? jtb_pkg::ST_SELDR : jtb_pkg::ST_RTI;
            jtb_pkg::ST_SELDR: r_next.state = tms ? jtb_pkg::ST_SELIR : jtb_pkg::ST_CAPDR;
            jtb_pkg::ST_CAPDR: r_next.state = tms ? jtb_pkg::ST_EX1DR : jtb_pkg::ST_SHDR;
            jtb_pkg::ST_SHDR:  r_next.state = tms ? jtb_pkg::ST_EX1DR : jtb_pkg::ST_SHDR;
            jtb_pkg::ST_EX1DR: r_next.state = tms ? jtb_pkg::ST_UPDR  : jtb_pkg::ST_PSDR;
            jtb_pkg::ST_PSDR:  r_next.state = tms ? jtb_pkg::ST_EX2DR : jtb_pkg::ST_PSDR;
            jtb_pkg::ST_EX2DR: r_next.state = tms ? jtb_pkg::ST_UPDR  : jtb_pkg::ST_SHDR;
            jtb_pkg::ST_UPDR:  r_next.state = tms ? jtb_pkg::ST_SELDR : jtb_pkg::ST_RTI;
            jtb_pkg::ST_SELIR: r_next.state = tms ? jtb_pkg::ST_TLR   : jtb_pkg::ST_CAPIR;
            jtb_pkg::ST_CAPIR: r_next.state = tms ? jtb_pkg::ST_EX1IR : jtb_pkg::ST_SHIR;
            jtb_pkg::ST_SHIR:  r_next.state = tms ? jtb_pkg::ST_EX1IR : jtb_pkg::ST_SHIR;
            jtb_pkg::ST_EX1IR: r_next.state = tms ? jtb_pkg::ST_UPIR  : jtb_pkg::ST_PSIR;
            jtb_pkg::ST_PSIR:  r_next.state = tms ? jtb_pkg::ST_EX2IR : jtb_pkg::ST_PSIR;
            jtb_pkg::ST_EX2IR: r_next.state = tms ? jtb_pkg::ST_UPIR  : jtb_pkg::ST_SHIR;
            jtb_pkg::ST_UPIR:  r_next.state = tms ? jtb_pkg::ST_SELDR : jtb_pkg::ST_RTI;
            default:           r_next.state = jtb_pkg::ST_TLR;
         endcase
         // register actions on the rising edge
         case (r_reg.state)
            jtb_pkg::ST_TLR:   r_next.ir = jtb_pkg::IR_RESET;
            jtb_pkg::ST_CAPIR: r_next.ir_sh = jtb_pkg::IR_CAPTURE;
            jtb_pkg::ST_SHIR:  r_next.ir_sh = {tdi, r_reg.ir_sh[3:1]};
            jtb_pkg::ST_UPIR:  r_next.ir = r_reg.ir_sh;
            jtb_pkg::ST_CAPDR: begin
               r_next.dr_sh = ID_VALUE;
               r_next.byp   = 1'h0;
            end
            jtb_pkg::ST_SHDR: begin
               r_next.dr_sh = {tdi, r_reg.dr_sh[31:1]};
               r_next.byp   = tdi;
            end
            default: r_next.ir = r_reg.ir;
         endcase
      end
      if (r_reg.test_en) begin
         // dedicated pins; user drive never reaches them
         r_next.pad_oe_n[2:0] = 3'h7;
         r_next.user_in       = '0;
         if (tck_fall) begin
            r_next.pad_oe_n[jtb_pkg::PIN_TDO] = ~shifting;
            if (r_reg.state == jtb_pkg::ST_SHIR) begin
               r_next.pad_out[jtb_pkg::PIN_TDO] = r_reg.ir_sh[0];
            end else if (sel_id) begin
               r_next.pad_out[jtb_pkg::PIN_TDO] = r_reg.dr_sh[0];
            end else begin
               r_next.pad_out[jtb_pkg::PIN_TDO] = r_reg.byp;
            end
         end
      end else begin
         // general io mode
         r_next.state    = jtb_pkg::ST_TLR;
         r_next.pad_out  = USER_OUT_IN;
         r_next.pad_oe_n = USER_OE_N_IN;
         r_next.user_in  = pad_s;
      end
      // power-up reset stands in for a test reset pin
      if (!RSTN_IN) begin
         r_next          = '0;
         r_next.state    = jtb_pkg::ST_TLR;
         r_next.ir       = jtb_pkg::IR_RESET;
         r_next.test_en  = 1'h1;
         r_next.pad_out  = jtb_pkg::PIN_OUT_RST;
         r_next.pad_oe_n = jtb_pkg::PIN_OE_N_RST;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      r_reg <= r_next;
   end

   // ==========================================
   // outputs straight from the state register
   assign PAD_OUT      = r_reg.pad_out;
   assign PAD_OE_N_OUT = r_reg.pad_oe_n;
   assign USER_IN_OUT  = r_reg.user_in;

   // ==========================================
   // assertions
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   AST_RESET_TLR: assert property ($rose(RSTN_IN) |-> r_reg.state == jtb_pkg::ST_TLR)
      else $error("controller not in reset state after reset");
   AST_BYPASS_SHIFT: assert property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_SHDR
      |=> r_reg.byp == $past(tdi))
      else $error("bypass stage did not take tdi");
   AST_ALL_ONES: assert property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_UPIR
      && r_reg.ir_sh == jtb_pkg::IR_BYPASS |=> r_reg.ir == jtb_pkg::IR_BYPASS)
      else $error("all ones scan did not load bypass");
   AST_ID_CAPTURE: assert property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_CAPDR
      |=> r_reg.dr_sh == ID_VALUE)
      else $error("identification value not captured");
   AST_TDI_RISE: assert property (!tck_rise && r_reg.state == jtb_pkg::ST_SHIR
      |=> $stable(r_reg.ir_sh))
      else $error("instruction shifted without rising edge");
   AST_TDO_FALL: assert property (r_reg.test_en && $past(r_reg.test_en) && !tck_fall
      |=> $stable(PAD_OUT[jtb_pkg::PIN_TDO]))
      else $error("tdo changed off a falling edge");
   AST_TDO_HIZ: assert property (r_reg.test_en && tck_fall && !shifting
      |=> PAD_OE_N_OUT[jtb_pkg::PIN_TDO])
      else $error("tdo driven outside shift");
   AST_GPIO: assert property (!r_reg.test_en && r_reg.cfg_done |=> PAD_OE_N_OUT == $past(USER_OE_N_IN))
      else $error("general io drive not passed");
   AST_BURIED: assert property (r_reg.test_en && r_reg.cfg_done |=> PAD_OE_N_OUT[2:0] == 3'h7)
      else $error("user logic reached a test pin");
   AST_TMS_STEP: assert property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_TLR && !tms
      |=> r_reg.state == jtb_pkg::ST_RTI)
      else $error("controller did not leave reset state");
   AST_OTHER_CODE: assert property (r_reg.state == jtb_pkg::ST_SHDR && tck_fall && r_reg.test_en
      && r_reg.ir != jtb_pkg::IR_IDCODE |=> PAD_OUT[jtb_pkg::PIN_TDO] == $past(r_reg.byp))
      else $error("non-id code did not use bypass");

   // serial output, capture values, instruction reset, controller hold in general io and pin ownership
   AST_BYPASS_CAPTURE: assert property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_CAPDR
      |=> !r_reg.byp)
      else $error("bypass stage did not capture zero");
   AST_TLR_IR: assert property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_TLR
      |=> r_reg.ir == jtb_pkg::IR_RESET)
      else $error("instruction not reset in reset state");
   AST_TDO_DRIVE: assert property (r_reg.test_en && tck_fall && shifting
      |=> !PAD_OE_N_OUT[jtb_pkg::PIN_TDO])
      else $error("tdo not driven while shifting");
   AST_IR_OUT: assert property (r_reg.test_en && tck_fall && r_reg.state == jtb_pkg::ST_SHIR
      |=> PAD_OUT[jtb_pkg::PIN_TDO] == $past(r_reg.ir_sh[0]))
      else $error("tdo did not show instruction bit");
   AST_ID_OUT: assert property (r_reg.test_en && tck_fall && r_reg.state == jtb_pkg::ST_SHDR && sel_id
      |=> PAD_OUT[jtb_pkg::PIN_TDO] == $past(r_reg.dr_sh[0]))
      else $error("tdo did not show identification bit");
   AST_IO_HELD: assert property (!r_reg.test_en && r_reg.cfg_done |=> r_reg.state == jtb_pkg::ST_TLR)
      else $error("controller moved in general io mode");
   AST_USER_QUIET: assert property (r_reg.test_en && r_reg.cfg_done |=> USER_IN_OUT == 4'h0)
      else $error("pin levels reached user logic in test mode");

   // ==========================================
   // cover points of the main scenarios
   COV_ID_SHIFT: cover property (r_reg.state == jtb_pkg::ST_SHDR && sel_id && tck_fall);
   COV_BYPASS_LOAD: cover property (r_reg.state == jtb_pkg::ST_UPIR && r_reg.ir_sh == jtb_pkg::IR_BYPASS);
   COV_GPIO: cover property (r_reg.cfg_done && !r_reg.test_en);
   COV_TLR_RETURN: cover property (r_reg.test_en && tck_rise && r_reg.state == jtb_pkg::ST_SELIR && tms);
   COV_IR_SHIFT: cover property (r_reg.state == jtb_pkg::ST_SHIR && tck_fall);
endmodule : jtb_tap
`default_nettype wire

// ===== bench/jtb_host.sv
// scan-chain host model that drives the test pins
`timescale 1ns/1ps
`default_nettype none
module jtb_host (
   input  wire logic tdo_in,
   output var  logic tck_out,
   output var  logic tms_out,
   output var  logic tdi_out
);
   int unsafe_cnt;
   // one test clock period of 200 ns, tdo taken at the end of the high phase
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      logic early;
      tms_out = tms;
      tdi_out = tdi;
      #100 tck_out = 1'h1;
      #25 early = tdo_in;
      #75 tdo = tdo_in;
      if (early !== tdo) unsafe_cnt++;
      tck_out = 1'h0;
   endtask : step
   // idle: clock still and low, tms high
   initial begin
      unsafe_cnt = 0;
      tck_out = 1'h0;
      tms_out = 1'h1;
      tdi_out = 1'h1;
   end
endmodule : jtb_host
`default_nettype wire

// ===== bench/jtb_tap_tb.sv
// self-checking testbench of the reduced test access port
`timescale 1ns/1ps
`default_nettype none
module jtb_tap_tb;
   localparam logic [31:0] ID_V = 32'h5A3C_96E1;  // arbitrary value
   logic        clk, rstn, cfg, tck, tms, tdi;
   logic [3:0]  user_out, user_oe_n, pad_out, pad_oe_n, user_in;
   logic [63:0] tdov;
   int          bad_count, cmp_count;
   // pad levels, pull-up wherever nobody drives
   wire logic [3:0] ext = {1'h1, tdi, tms, tck};
   wire logic [3:0] pad = (pad_oe_n & ext) | (~pad_oe_n & pad_out);
   jtb_host host_u (.tdo_in(pad[3]), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
   jtb_tap #(.ID_VALUE(ID_V)) dut_u (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CFG_TEST_EN_IN(cfg), .PAD_IN(pad),
      .PAD_OUT(pad_out), .PAD_OE_N_OUT(pad_oe_n), .USER_OUT_IN(user_out), .USER_OE_N_IN(user_oe_n),
      .USER_IN_OUT(user_in));
   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : wait_clk
   task automatic do_reset(input logic c);
      @(posedge clk) #2 rstn = 1'h0;
      cfg = c;
      wait_clk(6);
      rstn = 1'h1;
      wait_clk(4);
   endtask : do_reset
   // walk the controller, tdo of each period lsb first into tdov
   task automatic scan(input logic [63:0] tmsv, input logic [63:0] tdiv, input int n);
      logic b;
      for (int i = 0; i < n; i++) begin
         host_u.step(tmsv[i], tdiv[i], b);
         tdov[i] = b;
      end
   endtask : scan
   task automatic ir_load(input logic [3:0] c);
      scan(64'h183, (c == 4'hF) ? {64{1'h1}} : (64'(c) << 4), 10);
      check("ir capture", 32'(tdov[7:4]), 32'h1);
      check("tdo released ir", 32'(tdov[8]), 32'h1);
   endtask : ir_load
   task automatic dr_scan(input logic [31:0] d, input int n);
      scan(64'h1 | (64'h3 << (n + 2)), 64'(d) << 3, n + 5);
   endtask : dr_scan
   // ==========================================
   // scenarios
   task automatic t_reset;
      do_reset(1'h1);
      check("oe_n reset", 32'(pad_oe_n), 32'hF);
      check("out reset", 32'(pad_out), 32'h0);
      check("user in reset", 32'(user_in), 32'h0);
   endtask : t_reset
   task automatic t_idcode;
      scan(64'h0, 64'h0, 1);
      dr_scan(32'h0, 32);
      check("idcode", 32'(tdov >> 3), ID_V);
      check("tdo released dr", 32'(tdov[35]), 32'h1);
   endtask : t_idcode
   task automatic t_codes;
      logic [3:0] codes [8] = '{4'hF, 4'h0, 4'h9, 4'hA, 4'hB, 4'hC, 4'h2, 4'h1};
      foreach (codes[k]) begin
         ir_load(codes[k]);
         dr_scan(32'hB5, 8);
         check("dr path", 32'(tdov >> 3) & 32'hFF, (codes[k] == 4'h1) ? 32'(ID_V[7:0]) : 32'h6A);
      end
   endtask : t_codes
   // walk through reset state: instruction must fall back to identification
   task automatic t_tlr;
      ir_load(4'hF);
      scan(64'h7, 64'h0, 4);
      dr_scan(32'h0, 32);
      check("id after tlr", 32'(tdov >> 3), ID_V);
   endtask : t_tlr
   task automatic t_buried;
      @(posedge clk) #2 user_oe_n = 4'h0;
      user_out = 4'hA;
      wait_clk(4);
      check("pins kept", 32'(pad_oe_n), 32'hF);
      check("user in test", 32'(user_in), 32'h0);
   endtask : t_buried
   task automatic t_io;
      logic b;
      do_reset(1'h0);
      check("io oe", 32'(pad_oe_n), 32'h0);
      check("io out", 32'(pad_out), 32'hA);
      @(posedge clk) #2 user_oe_n = 4'hF;
      repeat (6) host_u.step(1'h0, 1'h1, b);
      wait_clk(4);
      check("io in", 32'(user_in), 32'hC);
      check("io tdo idle", 32'(pad_oe_n), 32'hF);
   endtask : t_io
   // ==========================================
   // clock, main sequence and watchdog
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      bad_count = 0;
      cmp_count = 0;
      rstn = 1'h0;
      cfg = 1'h1;
      user_out = 4'h0;
      user_oe_n = 4'hF;
      t_reset;
      t_idcode;
      t_codes;
      t_tlr;
      t_buried;
      t_io;
      t_reset;
      check("tdo steady", 32'(host_u.unsafe_cnt), 32'h0);
      end_sim;
   end
   initial begin
      #400000;
      bad_count++;
      end_sim;
   end
endmodule : jtb_tap_tb
`default_nettype wire
